/* logic/csfb_status_bank.sv */
`timescale 1ns/100ps
`include "csfb_consts.svh"

module csfb_status_bank (
    input wire logic core_clk,
    input wire logic srst,
    input csfb_pkg::csfb_op_s op,
    input csfb_pkg::csfb_arith_s arith,
    input csfb_pkg::csfb_test_s test_res,
    input wire logic overflow,
    input wire logic ovf_branch,
    input wire logic shift_carry_valid,
    input wire logic shift_carry,
    input wire logic trap_taken,
    input wire logic no_extend_add,
    input wire logic [6:0] dir_offset,
    input wire logic [31:0] product_reg,
    output logic [15:0] status_word_zero,
    output logic [15:0] status_word_one,
    output logic store_valid,
    output logic [15:0] store_data,
    output csfb_pkg::csfb_fields_s fields,
    output logic [15:0] direct_addr,
    output logic maskable_irq_enable,
    output logic ram_in_program_space,
    output logic sign_extend_active,
    output logic ext_flag_pin,
    output logic [31:0] product_scaled
);
    import csfb_pkg::*;

    // ************************************************************
    // Word packing helpers
    // ************************************************************

    // Builds the readable form of word zero with reserved bits at one.
    function automatic logic [15:0] pack_w0(input csfb_fields_s f);
        logic [15:0] w;
        w = `CSFB_W0_RSVD;
        w[`CSFB_ARP_POS +: 3] = f.aux_ptr;
        w[`CSFB_OV_POS] = f.ovf;
        w[`CSFB_OVM_POS] = f.sat;
        w[`CSFB_GLOBAL_IRQ_MASK_POS] = f.global_irq_mask;
        w[`CSFB_DP_POS +: 9] = f.dp;
        return w;
    endfunction

    // Builds the readable form of word one with reserved bits at one.
    function automatic logic [15:0] pack_w1(input csfb_fields_s f);
        logic [15:0] w;
        w = `CSFB_W1_RSVD;
        w[`CSFB_ARB_POS +: 3] = f.aux_ptr_backup;
        w[`CSFB_CNF_POS] = f.ram_map_select;
        w[`CSFB_TC_POS] = f.tc;
        w[`CSFB_SXM_POS] = f.sign_extend_enable;
        w[`CSFB_C_POS] = f.carry;
        w[`CSFB_XF_POS] = f.xf;
        w[`CSFB_PM_POS +: 2] = f.pm;
        return w;
    endfunction

    // ************************************************************
    // Current state and word images
    // ************************************************************

    csfb_fields_s cur;
    csfb_fields_s nxt;
    logic [15:0] w0_cur;
    logic [15:0] w1_cur;
    logic [15:0] w0_bit;
    logic [15:0] w1_bit;
    logic [15:0] w1_rst;
    logic [15:0] bit_mask;
    logic is_bit_op;
    logic bit_w0;
    logic bit_w1;
    logic aux_direct;
    logic arp_by_bit;
    logic [31:0] product_shifted;

    // Decodes the command into word-level edits for bit set and clear.
    assign w0_cur = pack_w0(cur);
    assign w1_cur = pack_w1(cur);
    assign w1_rst = `CSFB_W1_RESET;
    assign bit_mask = 16'h0001 << op.bit_pos;
    assign is_bit_op = (op.code == CSFB_BIT_SET) || (op.code == CSFB_BIT_CLEAR);
    assign bit_w0 = is_bit_op && !op.bit_word;
    assign bit_w1 = is_bit_op && op.bit_word;
    assign w0_bit = (op.code == CSFB_BIT_SET) ? (w0_cur | bit_mask) : (w0_cur & ~bit_mask);
    assign w1_bit = (op.code == CSFB_BIT_SET) ? (w1_cur | bit_mask) : (w1_cur & ~bit_mask);
    assign arp_by_bit = bit_w0 && (op.bit_pos >= 4'hD);
    assign aux_direct = (op.code == CSFB_LOAD_AUX_PTR) || (op.code == CSFB_MODIFY_AUX) ||
                        (op.code == CSFB_INDIRECT_AUX);

    // ************************************************************
    // Auxiliary pointer and backup
    // ************************************************************

    logic [2:0] aux_ptr_reg;
    logic [2:0] arb_reg;

    // Pointer loads from word zero, word one, bit edits or pointer instructions.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            aux_ptr_reg <= 3'h0;
        end else if (op.code == CSFB_LOAD_W0) begin
            aux_ptr_reg <= op.data[`CSFB_ARP_POS +: 3];
        end else if (op.code == CSFB_LOAD_W1) begin
            aux_ptr_reg <= op.data[`CSFB_ARB_POS +: 3];
        end else if (aux_direct) begin
            aux_ptr_reg <= op.data[2:0];
        end else if (bit_w0) begin
            aux_ptr_reg <= w0_bit[`CSFB_ARP_POS +: 3];
        end
    end

    // Backup keeps the old pointer whenever the pointer moves outside a status load.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            arb_reg <= 3'h0;
        end else if (op.code == CSFB_LOAD_W1) begin
            arb_reg <= op.data[`CSFB_ARB_POS +: 3];
        end else if (aux_direct || arp_by_bit) begin
            arb_reg <= aux_ptr_reg;
        end else if (bit_w1) begin
            arb_reg <= w1_bit[`CSFB_ARB_POS +: 3];
        end
    end

    // ************************************************************
    // Word zero fields
    // ************************************************************

    logic ovf_reg;
    logic sat_reg;
    logic global_irq_mask_reg;
    logic [8:0] dp_reg;

    // Overflow latch; a new overflow wins over every clear except reset in the same cycle.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            ovf_reg <= 1'b0;
        end else if (overflow) begin
            ovf_reg <= 1'b1;
        end else if (op.code == CSFB_LOAD_W0) begin
            ovf_reg <= op.data[`CSFB_OV_POS];
        end else if (bit_w0) begin
            ovf_reg <= w0_bit[`CSFB_OV_POS];
        end else if (ovf_branch) begin
            ovf_reg <= 1'b0;
        end
    end

    // Saturation mode from status loads and bit edits.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sat_reg <= 1'b0;
        end else if (op.code == CSFB_LOAD_W0) begin
            sat_reg <= op.data[`CSFB_OVM_POS];
        end else if (bit_w0) begin
            sat_reg <= w0_bit[`CSFB_OVM_POS];
        end
    end

    // Interrupt mask; every set source wins over the bit clear, status load leaves it.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            global_irq_mask_reg <= 1'b1;
        end else if (trap_taken || op.code == CSFB_IRQ_ACK) begin
            global_irq_mask_reg <= 1'b1;
        end else if (bit_w0) begin
            global_irq_mask_reg <= w0_bit[`CSFB_GLOBAL_IRQ_MASK_POS];
        end
    end

    // Data page pointer from page loads, status loads and bit edits.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            dp_reg <= 9'h000;
        end else if (op.code == CSFB_LOAD_W0) begin
            dp_reg <= op.data[`CSFB_DP_POS +: 9];
        end else if (op.code == CSFB_LOAD_PAGE) begin
            dp_reg <= op.data[8:0];
        end else if (bit_w0) begin
            dp_reg <= w0_bit[`CSFB_DP_POS +: 9];
        end
    end

    // ************************************************************
    // Word one fields
    // ************************************************************

    logic cnf_reg;
    logic tc_reg;
    logic sxm_reg;
    logic carry_reg;
    logic xf_reg;
    logic [1:0] pm_reg;

    // Gathers the field registers into one struct for packing.
    always_comb begin
        cur.aux_ptr = aux_ptr_reg;
        cur.aux_ptr_backup = arb_reg;
        cur.ovf = ovf_reg;
        cur.sat = sat_reg;
        cur.global_irq_mask = global_irq_mask_reg;
        cur.dp = dp_reg;
        cur.ram_map_select = cnf_reg;
        cur.tc = tc_reg;
        cur.sign_extend_enable = sxm_reg;
        cur.carry = carry_reg;
        cur.xf = xf_reg;
        cur.pm = pm_reg;
    end

    // RAM map select from word one load or bit edits.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cnf_reg <= w1_rst[`CSFB_CNF_POS];
        end else if (op.code == CSFB_LOAD_W1) begin
            cnf_reg <= op.data[`CSFB_CNF_POS];
        end else if (bit_w1) begin
            cnf_reg <= w1_bit[`CSFB_CNF_POS];
        end
    end

    // Test flag takes the result of the latest test instruction.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tc_reg <= w1_rst[`CSFB_TC_POS];
        end else if (op.code == CSFB_LOAD_W1) begin
            tc_reg <= op.data[`CSFB_TC_POS];
        end else if (bit_w1) begin
            tc_reg <= w1_bit[`CSFB_TC_POS];
        end else if (test_res.valid) begin
            tc_reg <= test_res.result;
        end
    end

    // Sign extension mode from word one load or bit edits.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sxm_reg <= w1_rst[`CSFB_SXM_POS];
        end else if (op.code == CSFB_LOAD_W1) begin
            sxm_reg <= op.data[`CSFB_SXM_POS];
        end else if (bit_w1) begin
            sxm_reg <= w1_bit[`CSFB_SXM_POS];
        end
    end

    // Carry from commands first, then shifts, then add and subtract results.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            carry_reg <= w1_rst[`CSFB_C_POS];
        end else if (op.code == CSFB_LOAD_W1) begin
            carry_reg <= op.data[`CSFB_C_POS];
        end else if (bit_w1) begin
            carry_reg <= w1_bit[`CSFB_C_POS];
        end else if (shift_carry_valid) begin
            carry_reg <= shift_carry;
        end else if (arith.valid && arith.shift16) begin
            if (arith.is_sub) begin
                carry_reg <= carry_reg & ~arith.carry_borrow;
            end else begin
                carry_reg <= carry_reg | arith.carry_borrow;
            end
        end else if (arith.valid) begin
            carry_reg <= arith.is_sub ? ~arith.carry_borrow : arith.carry_borrow;
        end
    end

    // External flag follows bit edits only.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            xf_reg <= w1_rst[`CSFB_XF_POS];
        end else if (bit_w1) begin
            xf_reg <= w1_bit[`CSFB_XF_POS];
        end
    end

    // Product shift select from the shift command or word one load.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pm_reg <= `CSFB_PM_NONE;
        end else if (op.code == CSFB_LOAD_W1) begin
            pm_reg <= op.data[`CSFB_PM_POS +: 2];
        end else if (op.code == CSFB_SET_SHIFT) begin
            pm_reg <= op.data[1:0];
        end else if (bit_w1) begin
            pm_reg <= w1_bit[`CSFB_PM_POS +: 2];
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    logic [2:0] aux_ptr_d;
    logic [2:0] arb_d;
    logic [8:0] dp_d;
    assign aux_ptr_d = aux_ptr_reg;
    assign arb_d = arb_reg;
    assign dp_d = dp_reg;

    // Current-state view, so every output flop lags the field flops by one cycle.
    always_comb begin
        nxt = cur;
        nxt.aux_ptr = aux_ptr_d;
        nxt.aux_ptr_backup = arb_d;
        nxt.dp = dp_d;
    end

    csfb_prod_shift u_prod_shift (
        .product_in(product_reg),
        .shift_sel(pm_reg),
        .product_out(product_shifted)
    );

    // Registered images of the status words and derived controls.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            status_word_zero <= `CSFB_W0_RESET;
            status_word_one <= `CSFB_W1_RESET;
            fields <= '0;
            direct_addr <= 16'h0000;
            maskable_irq_enable <= 1'b0;
            ram_in_program_space <= 1'b0;
            sign_extend_active <= 1'b0;
            ext_flag_pin <= 1'b1;
            product_scaled <= 32'h0000_0000;
        end else begin
            status_word_zero <= pack_w0(nxt);
            status_word_one <= pack_w1(nxt);
            fields <= nxt;
            direct_addr <= {dp_reg, dir_offset};
            maskable_irq_enable <= ~global_irq_mask_reg;
            ram_in_program_space <= cnf_reg;
            sign_extend_active <= sxm_reg & ~no_extend_add;
            ext_flag_pin <= xf_reg;
            product_scaled <= product_shifted;
        end
    end

    // Store port hands the current word to data memory.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            store_valid <= 1'b0;
            store_data <= 16'h0000;
        end else begin
            store_valid <= (op.code == CSFB_STORE_W0) || (op.code == CSFB_STORE_W1);
            store_data <= (op.code == CSFB_STORE_W1) ? w1_cur : w0_cur;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_aux_move;
        aux_direct && !overflow;
    endsequence

    sequence s_load_w1;
        op.code == CSFB_LOAD_W1;
    endsequence

    a_global_irq_mask_load_keep: assert property ((op.code == CSFB_LOAD_W0) && !trap_taken |=>
        global_irq_mask_reg == $past(global_irq_mask_reg)) else $error("mask changed by word load");
    a_rsvd_ones: assert property (((status_word_zero & `CSFB_W0_RSVD) == `CSFB_W0_RSVD) &&
        ((status_word_one & `CSFB_W1_RSVD) == `CSFB_W1_RSVD)) else $error("reserved not one");
    a_backup_copy: assert property (s_aux_move |=>
        (arb_reg == $past(aux_ptr_reg)) && (aux_ptr_reg == $past(op.data[2:0])))
        else $error("backup missed old pointer");
    a_w1_pointer: assert property (s_load_w1 |=> aux_ptr_reg == arb_reg)
        else $error("pointer not copied from backup");
    a_carry_plain: assert property ((op.code == CSFB_NOP) && !shift_carry_valid && arith.valid &&
        !arith.shift16 |=> carry_reg == ($past(arith.is_sub) ^ $past(arith.carry_borrow)))
        else $error("carry wrong after add or subtract");
    a_carry_shift16: assert property ((op.code == CSFB_NOP) && !shift_carry_valid &&
        arith.valid && arith.shift16 && !arith.carry_borrow |=> $stable(carry_reg))
        else $error("carry moved without cause");
    a_ovf_sticky: assert property (overflow |=> ovf_reg ##1 (ovf_reg ||
        $past(ovf_branch) || $past(op.code == CSFB_LOAD_W0) || $past(bit_w0)))
        else $error("overflow latch lost");
    a_global_irq_mask_sets: assert property (trap_taken || op.code == CSFB_IRQ_ACK |=> global_irq_mask_reg ##1
        maskable_irq_enable == 1'b0) else $error("mask not set");
    a_pin_follows: assert property (bit_w1 && op.bit_pos == 4'h4 |=> ##1
        ext_flag_pin == $past(op.code == CSFB_BIT_SET, 2))
        else $error("flag pin did not follow");
    a_page_addr: assert property (op.code == CSFB_LOAD_PAGE |=> ##1
        direct_addr[15:7] == $past(op.data[8:0], 2)) else $error("direct address wrong");

endmodule

/* logic/csfb_consts.svh */
// Functional notes
// - load_status_op writes either status word; store_status_op copies either word out.
// - A whole-word load of status word zero never changes global_irq_mask.
// - Reserved bits read as one; bit_set_op and bit_clear_op reach every bit.
// - A new aux_ptr first copies the old one into aux_ptr_backup, except load_status_op.
// - Loading aux_ptr_backup by the word one load also loads aux_ptr.
// - aux_ptr picks the indirect register; indirect, load, modify and status loads change it.
// - Carry: one on add carry, zero on subtract borrow, else clear after add, set after sub.
// - With sixteen-place shift, add may only set carry and subtract only clear it.
// - Shifts, bit ops and word one load update carry; reset sets it; it is a condition.
// - Nine-bit page pointer joins seven instruction bits into a direct address.
// - global_irq_mask one blocks maskable interrupts only, never reset or nonmaskable.
// - Reset, acknowledge, bit set and trap set the mask; only bit clear clears it.
// - Overflow latch sets on any overflow; reset, overflow branch or status load clears.
// - saturate_enable chooses wrap or clamp; bit ops and status loads modify it.
// - Product shift codes: none, left one, left four, right six sign-extended.
// - Product shift acts on the path only; shift op and word one load set it.
// - sign_extend_enable steers extension; the no-extend add always suppresses it.
// - sign_extend_enable: bit set, bit clear, word one load, reset to one.
// - Branches may test test_flag; the word one load can write it.
// - ext_flag_pin drives the output pin; bit ops set or clear it; reset sets it.
`ifndef CSFB_CONSTS_SVH
`define CSFB_CONSTS_SVH

`define CSFB_WORD_W 16
`define CSFB_ARP_POS 13
`define CSFB_OV_POS 12
`define CSFB_OVM_POS 11
`define CSFB_GLOBAL_IRQ_MASK_POS 9
`define CSFB_DP_POS 0
`define CSFB_ARB_POS 13
`define CSFB_CNF_POS 12
`define CSFB_TC_POS 11
`define CSFB_SXM_POS 10
`define CSFB_C_POS 9
`define CSFB_XF_POS 4
`define CSFB_PM_POS 0
`define CSFB_W0_RSVD 16'h0400
`define CSFB_W1_RSVD 16'h01EC
`define CSFB_W0_RESET 16'h0600
`define CSFB_W1_RESET 16'h07FC
`define CSFB_PM_NONE 2'h0
`define CSFB_PM_LEFT1 2'h1
`define CSFB_PM_LEFT4 2'h2
`define CSFB_PM_RIGHT6 2'h3

`endif

/* logic/csfb_pkg.sv */
package csfb_pkg;

    // Commands that the instruction decoder issues, at most one a cycle.
    typedef enum logic [3:0] {
        CSFB_NOP,
        CSFB_LOAD_W0,
        CSFB_LOAD_W1,
        CSFB_STORE_W0,
        CSFB_STORE_W1,
        CSFB_BIT_SET,
        CSFB_BIT_CLEAR,
        CSFB_LOAD_AUX_PTR,
        CSFB_MODIFY_AUX,
        CSFB_INDIRECT_AUX,
        CSFB_LOAD_PAGE,
        CSFB_SET_SHIFT,
        CSFB_IRQ_ACK
    } csfb_op_e;

    typedef struct packed {
        csfb_op_e code;
        logic [15:0] data;
        logic bit_word;
        logic [3:0] bit_pos;
    } csfb_op_s;

    typedef struct packed {
        logic valid;
        logic is_sub;
        logic shift16;
        logic carry_borrow;
    } csfb_arith_s;

    typedef struct packed {
        logic valid;
        logic result;
    } csfb_test_s;

    typedef struct packed {
        logic [2:0] aux_ptr;
        logic [2:0] aux_ptr_backup;
        logic ovf;
        logic sat;
        logic global_irq_mask;
        logic [8:0] dp;
        logic ram_map_select;
        logic tc;
        logic sign_extend_enable;
        logic carry;
        logic xf;
        logic [1:0] pm;
    } csfb_fields_s;

endpackage

/* logic/csfb_prod_shift.sv */
`timescale 1ns/100ps
`include "csfb_consts.svh"

module csfb_prod_shift (
    input wire logic [31:0] product_in,
    input wire logic [1:0] shift_sel,
    output logic [31:0] product_out
);

    // Reshapes the product on its way to the ALU; the stored product is untouched.
    always_comb begin
        case (shift_sel)
            `CSFB_PM_NONE: product_out = product_in;
            `CSFB_PM_LEFT1: product_out = {product_in[30:0], 1'b0};
            `CSFB_PM_LEFT4: product_out = {product_in[27:0], 4'h0};
            `CSFB_PM_RIGHT6: product_out = {{6{product_in[31]}}, product_in[31:6]};
            default: product_out = product_in;
        endcase
    end

endmodule

/* bench/csfb_core_model.sv */
`timescale 1ns/100ps

// ****************************************
// Decoder stand-in that issues commands.
// ****************************************
module csfb_core_model (
    input wire logic core_clk,
    output csfb_pkg::csfb_op_s op,
    output csfb_pkg::csfb_arith_s arith,
    output csfb_pkg::csfb_test_s test_res
);
    import csfb_pkg::*;

    // The decoder sits idle until the bench asks for a command.
    initial begin
        op = '0;
        arith = '0;
        test_res = '0;
    end

    // A command stands for exactly one cycle and then falls back to idle.
    task automatic issue(input csfb_op_s o, input csfb_arith_s a, input csfb_test_s t);
        @(posedge core_clk);
        op <= o;
        arith <= a;
        test_res <= t;
        @(posedge core_clk);
        op <= '0;
        arith <= '0;
        test_res <= '0;
    endtask
endmodule

/* bench/cpu_status_flag_bank_tb_top.sv */
`timescale 1ns/100ps
`include "csfb_consts.svh"

// ****************************************
// Bench for the status and control words.
// ****************************************
module cpu_status_flag_bank_tb_top;
    import csfb_pkg::*;
    logic core_clk;
    logic srst = 1'b1;
    logic [3:0] evt = 4'h0;
    logic shift_carry = 1'b0;
    logic no_extend_add = 1'b0;
    logic [6:0] dir_offset;
    logic [31:0] product_reg;
    csfb_op_s op;
    csfb_arith_s arith;
    csfb_test_s test_res;
    csfb_fields_s f;
    logic [15:0] w0, w1, store_data, direct_addr, e0, e1;
    logic store_valid, irq_en, ram_prog, sx_act, xf;
    logic [31:0] p_scaled;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 6125;

    csfb_core_model partner_u (.core_clk(core_clk), .op(op), .arith(arith), .test_res(test_res));

    csfb_status_bank dut_u (
        .core_clk(core_clk), .srst(srst), .op(op), .arith(arith), .test_res(test_res),
        .overflow(evt[0]), .ovf_branch(evt[1]), .shift_carry_valid(evt[2]),
        .shift_carry(shift_carry), .trap_taken(evt[3]), .no_extend_add(no_extend_add),
        .dir_offset(dir_offset), .product_reg(product_reg), .status_word_zero(w0),
        .status_word_one(w1), .store_valid(store_valid), .store_data(store_data),
        .fields(f), .direct_addr(direct_addr), .maskable_irq_enable(irq_en),
        .ram_in_program_space(ram_prog), .sign_extend_active(sx_act),
        .ext_flag_pin(xf), .product_scaled(p_scaled)
    );

    // Free-running core clock.
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // A hung run is cut short and counted as a mismatch.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end

    // ****************************************
    // Comparison, model and stimulus tasks.
    // ****************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Product as it should look after the transfer-path shifter.
    function automatic logic [31:0] scale(input logic [1:0] pm);
        case (pm)
            2'h1: return product_reg << 1;
            2'h2: return product_reg << 4;
            2'h3: return $signed(product_reg) >>> 6;
            default: return product_reg;
        endcase
    endfunction

    task automatic check_all();
        chk("word0", w0, e0);
        chk("word1", w1, e1);
        chk("fields", f, {e0[15:13], e1[15:13], e0[12:11], e0[9:0], e1[12:9], e1[4], e1[1:0]});
        chk("irq_enable", irq_en, !e0[9]);
        chk("ram_map", ram_prog, e1[12]);
        chk("ext_flag", xf, e1[4]);
        chk("sign_ext", sx_act, e1[10] & !no_extend_add);
        chk("direct_addr", direct_addr, {e0[8:0], dir_offset});
        chk("product", p_scaled, scale(e1[1:0]));
    endtask

    // Reference model: the command overrides arithmetic and test results.
    task automatic model(input csfb_op_e c, input logic [15:0] d, input logic bw,
                         input logic [3:0] bp, input csfb_arith_s a, input csfb_test_s t);
        if (a.valid && !a.shift16) e1[9] = a.is_sub ? !a.carry_borrow : a.carry_borrow;
        if (a.valid && a.shift16 && a.carry_borrow) e1[9] = !a.is_sub;
        if (t.valid) e1[11] = t.result;
        case (c)
            CSFB_LOAD_W0: e0 = (d & 16'hFDFF) | (e0 & 16'h0200);
            CSFB_LOAD_W1: begin
                e1 = (d & 16'hFFEF) | (e1 & 16'h0010);
                e0[15:13] = d[15:13];
            end
            CSFB_BIT_SET, CSFB_BIT_CLEAR: begin
                if (!bw && bp >= 13) e1[15:13] = e0[15:13];
                if (bw) e1[bp] = (c == CSFB_BIT_SET);
                else e0[bp] = (c == CSFB_BIT_SET);
            end
            CSFB_LOAD_AUX_PTR, CSFB_MODIFY_AUX, CSFB_INDIRECT_AUX: begin
                e1[15:13] = e0[15:13];
                e0[15:13] = d[2:0];
            end
            CSFB_LOAD_PAGE: e0[8:0] = d[8:0];
            CSFB_SET_SHIFT: e1[1:0] = d[1:0];
            CSFB_IRQ_ACK: e0[9] = 1'b1;
            default: ;
        endcase
        e0 |= `CSFB_W0_RSVD;
        e1 |= `CSFB_W1_RSVD;
    endtask

    // One command, then the words are checked once both output stages settle.
    task automatic do_op(input csfb_op_e c, input logic [15:0] d, input logic bw = 1'b0,
                         input logic [3:0] bp = 4'h0, input csfb_arith_s a = '0,
                         input csfb_test_s t = '0);
        partner_u.issue('{c, d, bw, bp}, a, t);
        #1;
        if (c == CSFB_STORE_W0 || c == CSFB_STORE_W1) begin
            chk("store_valid", store_valid, 1'b1);
            chk("store_data", store_data, c == CSFB_STORE_W0 ? e0 : e1);
        end
        model(c, d, bw, bp, a, t);
        repeat (2) @(posedge core_clk);
        #1;
        check_all();
    endtask

    // One-cycle pulse on an event input: overflow, branch, shift carry, trap.
    task automatic ev(input int k, input logic v);
        @(posedge core_clk);
        evt <= 4'h1 << k;
        shift_carry <= v;
        @(posedge core_clk);
        evt <= 4'h0;
        case (k)
            0: e0[12] = 1'b1;
            1: e0[12] = 1'b0;
            2: e1[9] = v;
            default: e0[9] = 1'b1;
        endcase
        repeat (2) @(posedge core_clk);
        #1;
        check_all();
    endtask

    // ****************************************
    // Main sequence.
    // ****************************************
    initial begin
        product_reg = $random(seed);
        dir_offset = 7'($random(seed));
        repeat (20) @(posedge core_clk);
        srst <= 1'b0;
        e0 = `CSFB_W0_RESET;
        e1 = `CSFB_W1_RESET;
        repeat (2) @(posedge core_clk);
        #1;
        check_all();
        for (int w = 0; w < 2; w++) begin
            for (int b = 0; b < 16; b++) begin
                do_op(CSFB_BIT_SET, 16'h0, w[0], b[3:0]);
                do_op(CSFB_BIT_CLEAR, 16'h0, w[0], b[3:0]);
            end
        end
        repeat (4) begin
            do_op(CSFB_LOAD_W0, 16'($random(seed)));
            do_op(CSFB_LOAD_W1, 16'($random(seed)));
            do_op(CSFB_STORE_W0, 16'h0);
            do_op(CSFB_STORE_W1, 16'h0);
            do_op(CSFB_LOAD_AUX_PTR, 16'($random(seed)));
            do_op(CSFB_MODIFY_AUX, 16'($random(seed)));
            do_op(CSFB_INDIRECT_AUX, 16'($random(seed)));
            do_op(CSFB_LOAD_PAGE, 16'($random(seed)));
        end
        for (int m = 0; m < 8; m++) begin
            if (m == 4) begin
                @(posedge core_clk);
                product_reg <= ~product_reg;
            end
            do_op(CSFB_SET_SHIFT, 16'(m));
        end
        for (int i = 0; i < 16; i++) begin
            do_op(i[3] ? CSFB_BIT_SET : CSFB_BIT_CLEAR, 16'h0, 1'b1, 4'h9);
            do_op(CSFB_NOP, 16'h0, 1'b0, 4'h0, '{1'b1, i[2], i[1], i[0]});
        end
        do_op(CSFB_BIT_CLEAR, 16'h0, 1'b0, 4'h9);
        ev(3, 1'b0);
        do_op(CSFB_BIT_CLEAR, 16'h0, 1'b0, 4'h9);
        do_op(CSFB_IRQ_ACK, 16'h0);
        ev(0, 1'b0);
        ev(1, 1'b0);
        ev(2, 1'b1);
        ev(2, 1'b0);
        do_op(CSFB_NOP, 16'h0, 1'b0, 4'h0, '0, '{1'b1, 1'b1});
        do_op(CSFB_NOP, 16'h0, 1'b0, 4'h0, '0, '{1'b1, 1'b0});
        do_op(CSFB_BIT_SET, 16'h0, 1'b1, 4'hA);
        @(posedge core_clk);
        no_extend_add <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        check_all();
        end_sim();
    end
endmodule
